/* hdl/timer_ctrl_consts.svh */
`ifndef TIMER_CTRL_CONSTS_SVH
`define TIMER_CTRL_CONSTS_SVH
// ==========================================================
// Register indices; the byte address is four times the index.
`define REG_MAIN_IDX    5'h00
`define REG_SYNC_READ_TRIGGER_IDX    5'h02
`define REG_CLR_IDX     5'h04
`define REG_SET_IDX     5'h05
`define REG_CAPINV_IDX  5'h06
`define REG_STATUS_IDX  5'h0f
`define REG_COUNT_IDX   5'h10
`define REG_TOP_IDX     5'h14
`define REG_CH0_IDX     5'h18
`define REG_CH1_IDX     5'h19
// ==========================================================
// Field positions.
`define MAIN_SOFT_RESET_TRIGGER      0
`define MAIN_EN         1
`define MAIN_WIDTH_LO   2
`define MAIN_WAVE_LO    5
`define MAIN_DIV_LO     8
`define SYNC_READ_TRIGGER_ADDR_LO    0
`define SYNC_READ_TRIGGER_CONT       14
`define SYNC_READ_TRIGGER_TRIG       15
`define CB_DIR          0
`define CB_SINGLE       2
`define CB_CMD_LO       6
`define CI_INV_LO       0
`define CI_CAP_LO       4
// ==========================================================
// Reset values and timing.
`define RST_DIV         3'h0
`define RST_TARGET      5'h00
`define RST_COUNT       32'h00000000
`define RST_TOP         8'hff
`define RST_CH          32'h00000000
`define SYNC_CYCLES     4'h3
`endif

/* hdl/timer_ctrl_pkg.sv */
package timer_ctrl_pkg;
	// ==========================================================
	// Mode and command encodings.
	typedef enum logic [1:0] {
		normal_frequency_mode   = 2'h0,
		match_frequency_mode    = 2'h1,
		normal_pulse_width_mode = 2'h2,
		match_pulse_width_mode  = 2'h3
	} wave_mode_t;
	typedef enum logic [1:0] {
		sixteen_bit_counting    = 2'h0,
		eight_bit_counting      = 2'h1,
		thirty_two_bit_counting = 2'h2,
		width_reserved          = 2'h3
	} width_mode_t;
	typedef enum logic [1:0] {
		cmd_none      = 2'h0,
		cmd_retrigger = 2'h1,
		cmd_stop      = 2'h2,
		cmd_reserved  = 2'h3
	} cmd_t;
endpackage

/* hdl/timer_link_if.sv */
`timescale 1ns/10ps
interface timer_link_if;
	logic [2:0] divider_sel;
	logic       run;
	logic       tick;
	logic       sync_start;
	logic       sync_done;
	logic       sync_busy;
	modport prescaler (input divider_sel, input run, output tick);
	modport syncer (input sync_start, output sync_done, output sync_busy);
	modport core (output divider_sel, output run, output sync_start,
		input tick, input sync_done, input sync_busy);
endinterface

/* hdl/timer_prescaler.sv */
`timescale 1ns/10ps
module timer_prescaler (
	// Clock and control.
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         ce,
	// Link to the core.
	timer_link_if.prescaler   lnk
);
	logic [9:0] div_cnt_r;
	logic [9:0] div_mask;

	// ==========================================================
	// Divide factors 1, 2, 4, 8, 16, 64, 256 and 1024.
	assign div_mask = (lnk.divider_sel == 3'h0) ? 10'h000 :
		(lnk.divider_sel == 3'h1) ? 10'h001 :
		(lnk.divider_sel == 3'h2) ? 10'h003 :
		(lnk.divider_sel == 3'h3) ? 10'h007 :
		(lnk.divider_sel == 3'h4) ? 10'h00f :
		(lnk.divider_sel == 3'h5) ? 10'h03f :
		(lnk.divider_sel == 3'h6) ? 10'h0ff : 10'h3ff;
	assign lnk.tick = lnk.run & ((div_cnt_r & div_mask) == div_mask);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_cnt_r <= 10'h000;
		end else if (ce) begin
			div_cnt_r <= lnk.run ? div_cnt_r + 10'h001 : 10'h000;
		end
	end
endmodule // timer_prescaler

/* hdl/timer_sync_delay.sv */
`timescale 1ns/10ps
`include "timer_ctrl_consts.svh"
module timer_sync_delay (
	// Clock and control.
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	// Link to the core.
	timer_link_if.syncer    lnk
);
	logic [3:0] hs_cnt_r;

	// ==========================================================
	// A new request restarts the wait so that every pending operation completes together.
	assign lnk.sync_busy = (hs_cnt_r != 4'h0);
	assign lnk.sync_done = (hs_cnt_r == 4'h1) & ~lnk.sync_start;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hs_cnt_r <= 4'h0;
		end else if (ce) begin
			hs_cnt_r <= lnk.sync_start ? `SYNC_CYCLES : hs_cnt_r - {3'h0, lnk.sync_busy};
		end
	end
endmodule // timer_sync_delay

/* hdl/timer_counter_control_regs.sv */
`timescale 1ns/10ps
`include "timer_ctrl_consts.svh"

module timer_counter_control_regs (
	// Clock, reset and clock enable.
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        ce,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Waveform outputs.
	output logic [1:0]       waveform_output
);
	timer_link_if lnk ();

	logic                        dp_wr_r;
	logic                        dp_rd_r;
	logic                        dp_map_r;
	logic [4:0]                  dp_idx_r;
	logic                        rd_wait_r;
	logic [31:0]                 hrdata_r;
	logic [2:0]                  div_sel_r;
	timer_ctrl_pkg::wave_mode_t  wave_sel_r;
	timer_ctrl_pkg::width_mode_t width_sel_r;
	logic                        enable_r;
	logic                        soft_reset_r;
	logic                        run_r;
	logic                        op_en_r;
	logic                        op_rst_r;
	logic                        op_rd_r;
	logic [4:0]                  rd_target_r;
	logic                        cont_r;
	logic                        armed_r;
	logic [31:0]                 shadow_r;
	logic                        dir_r;
	logic                        single_r;
	logic [1:0]                  cmd_r;
	logic [1:0]                  inv_r;
	logic [1:0]                  cap_r;
	logic [31:0]                 count_r;
	logic [31:0]                 count_nxt;
	logic                        stopped_r;
	logic                        stopped_nxt;
	logic [7:0]                  top_r;
	logic [31:0]                 ch_r [2];
	logic [1:0]                  wave_bits_r;
	logic [1:0]                  wave_nxt;
	logic [1:0]                  wo_r;
	logic [1:0]                  ch_match;
	logic [31:0]                 top_val;
	logic [31:0]                 cnt_mask;

	wire logic        addr_ok;
	wire logic        wr_go;
	wire logic        wr_main;
	wire logic        soft_req;
	wire logic        en_wr;
	wire logic        cfg_wr;
	wire logic        wipe_go;
	wire logic        sync_read_trigger_wr;
	wire logic        trig_wr;
	wire logic        set_wr;
	wire logic        clr_wr;
	wire logic        ci_wr;
	wire logic        cnt_wr;
	wire logic        top_wr;
	wire logic [1:0]  cmd_bits;
	wire logic        cmd_exec;
	wire logic        counting;
	wire logic        wrap;
	wire logic        match_top;
	wire logic        tgt_ok;
	wire logic [31:0] tgt_val;
	wire logic [31:0] rd_mux;
	wire logic [15:0] rd_main;
	wire logic [15:0] rd_sync_read_trigger;
	wire logic [7:0]  rd_cb;
	wire logic [7:0]  rd_ci;
	wire logic [7:0]  rd_status;
	wire logic [31:0] rd_count;
	wire logic [31:0] rd_ch0;
	wire logic [31:0] rd_ch1;

	// ==========================================================
	// Submodules.
	timer_prescaler u_presc (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.lnk     (lnk)
	);
	timer_sync_delay u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.lnk     (lnk)
	);
	assign lnk.divider_sel = div_sel_r;
	assign lnk.run = run_r;
	assign lnk.sync_start = en_wr | soft_req | trig_wr;

	// ==========================================================
	// Bus slave. Reads take one wait state so a write just before is always seen.
	assign addr_ok = hsel & hready & htrans[1];
	assign hreadyout = ~(dp_rd_r & ~rd_wait_r);
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dp_wr_r  <= 1'b0;
			dp_rd_r  <= 1'b0;
			dp_map_r <= 1'b0;
			dp_idx_r <= 5'h00;
		end else if (ce && hready) begin
			dp_wr_r  <= addr_ok & hwrite;
			dp_rd_r  <= addr_ok & ~hwrite;
			dp_map_r <= (haddr[31:7] == 25'h0000000);
			dp_idx_r <= haddr[6:2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_wait_r <= 1'b0;
			hrdata_r  <= 32'h00000000;
		end else if (ce) begin
			rd_wait_r <= ~hready & dp_rd_r;
			if (dp_rd_r && !rd_wait_r) begin
				hrdata_r <= dp_map_r ? rd_mux : 32'h00000000;
			end
		end
	end

	// ==========================================================
	// Write decode.
	assign wr_go    = ce & dp_wr_r & dp_map_r & hready;
	assign wr_main  = wr_go & (dp_idx_r == `REG_MAIN_IDX);
	assign soft_req = wr_main & hwdata[`MAIN_SOFT_RESET_TRIGGER];
	assign en_wr    = wr_main & ~hwdata[`MAIN_SOFT_RESET_TRIGGER];
	assign cfg_wr   = en_wr & ~run_r & ~enable_r & ~soft_reset_r;
	assign wipe_go  = ce & lnk.sync_done & op_rst_r;
	assign sync_read_trigger_wr  = wr_go & (dp_idx_r == `REG_SYNC_READ_TRIGGER_IDX);
	assign trig_wr  = sync_read_trigger_wr & hwdata[`SYNC_READ_TRIGGER_TRIG];
	assign set_wr   = wr_go & (dp_idx_r == `REG_SET_IDX);
	assign clr_wr   = wr_go & (dp_idx_r == `REG_CLR_IDX);
	assign ci_wr    = wr_go & (dp_idx_r == `REG_CAPINV_IDX);
	assign cnt_wr   = wr_go & (dp_idx_r == `REG_COUNT_IDX);
	assign top_wr   = wr_go & (dp_idx_r == `REG_TOP_IDX);
	assign cmd_bits = hwdata[`CB_CMD_LO +: 2];

	// ==========================================================
	// Main control.
	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			div_sel_r    <= `RST_DIV;
			wave_sel_r   <= timer_ctrl_pkg::normal_frequency_mode;
			width_sel_r  <= timer_ctrl_pkg::sixteen_bit_counting;
			enable_r     <= 1'b0;
			soft_reset_r <= 1'b0;
		end else if (ce) begin
			if (cfg_wr) begin
				div_sel_r   <= hwdata[`MAIN_DIV_LO +: 3];
				wave_sel_r  <= timer_ctrl_pkg::wave_mode_t'(hwdata[`MAIN_WAVE_LO +: 2]);
				width_sel_r <= timer_ctrl_pkg::width_mode_t'(hwdata[`MAIN_WIDTH_LO +: 2]);
			end
			if (en_wr) begin
				enable_r <= hwdata[`MAIN_EN];
			end
			if (soft_req) begin
				soft_reset_r <= 1'b1;
			end
		end
	end

	// Pending sync operations; a new request wins over the completion clear.
	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			op_en_r  <= 1'b0;
			op_rst_r <= 1'b0;
			op_rd_r  <= 1'b0;
		end else if (ce) begin
			op_en_r  <= en_wr | (op_en_r & ~lnk.sync_done);
			op_rst_r <= soft_req | op_rst_r;
			op_rd_r  <= trig_wr | (op_rd_r & ~lnk.sync_done);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			run_r <= 1'b0;
		end else if (ce && lnk.sync_done && op_en_r) begin
			run_r <= enable_r;
		end
	end

	// ==========================================================
	// Read synchronisation.
	assign tgt_ok = (rd_target_r == `REG_COUNT_IDX) | (rd_target_r == `REG_CH0_IDX)
		| (rd_target_r == `REG_CH1_IDX);
	assign tgt_val = (rd_target_r == `REG_COUNT_IDX) ? count_r :
		(rd_target_r == `REG_CH0_IDX) ? ch_r[0] : ch_r[1];

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			rd_target_r <= `RST_TARGET;
			cont_r      <= 1'b0;
			armed_r     <= 1'b0;
		end else if (ce && sync_read_trigger_wr) begin
			rd_target_r <= hwdata[`SYNC_READ_TRIGGER_ADDR_LO +: 5];
			cont_r      <= hwdata[`SYNC_READ_TRIGGER_CONT];
			armed_r     <= hwdata[`SYNC_READ_TRIGGER_CONT] & (hwdata[`SYNC_READ_TRIGGER_TRIG] | armed_r);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			shadow_r <= `RST_COUNT;
		end else if (ce && tgt_ok && ((lnk.sync_done && op_rd_r) || (cont_r && armed_r))) begin
			shadow_r <= tgt_val;
		end
	end

	// ==========================================================
	// Control B, shared by the set and clear views.
	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			dir_r    <= 1'b0;
			single_r <= 1'b0;
		end else if (ce) begin
			if (set_wr && hwdata[`CB_DIR]) begin
				dir_r <= 1'b1;
			end else if (clr_wr && hwdata[`CB_DIR]) begin
				dir_r <= 1'b0;
			end
			if (set_wr && hwdata[`CB_SINGLE]) begin
				single_r <= 1'b1;
			end else if (clr_wr && hwdata[`CB_SINGLE]) begin
				single_r <= 1'b0;
			end
		end
	end

	// An issue in the execute cycle survives the clear.
	assign cmd_exec = ce & lnk.tick & run_r & (cmd_r != 2'h0);

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			cmd_r <= timer_ctrl_pkg::cmd_none;
		end else if (ce) begin
			if (set_wr && cmd_bits != 2'h0) begin
				cmd_r <= cmd_bits;
			end else if ((clr_wr && cmd_bits != 2'h0) || cmd_exec) begin
				cmd_r <= timer_ctrl_pkg::cmd_none;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			inv_r <= 2'h0;
			cap_r <= 2'h0;
		end else if (ce && ci_wr) begin
			inv_r <= hwdata[`CI_INV_LO +: 2];
			cap_r <= hwdata[`CI_CAP_LO +: 2];
		end
	end

	// ==========================================================
	// Counter.
	assign match_top = (wave_sel_r == timer_ctrl_pkg::match_frequency_mode)
		| (wave_sel_r == timer_ctrl_pkg::match_pulse_width_mode);
	assign cnt_mask = (width_sel_r == timer_ctrl_pkg::eight_bit_counting) ? 32'h000000ff :
		(width_sel_r == timer_ctrl_pkg::thirty_two_bit_counting) ? 32'hffffffff
		: 32'h0000ffff;
	assign top_val = match_top ? (ch_r[0] & cnt_mask) :
		(width_sel_r == timer_ctrl_pkg::eight_bit_counting) ? {24'h000000, top_r}
		: cnt_mask;
	assign counting = ce & lnk.tick & run_r & ~stopped_r & ~cmd_exec;
	assign wrap = counting & (dir_r ? (count_r == 32'h00000000) : (count_r == top_val));

	always_comb begin
		count_nxt = count_r;
		stopped_nxt = stopped_r;
		if (cmd_exec && cmd_r == timer_ctrl_pkg::cmd_retrigger) begin
			count_nxt = dir_r ? top_val : 32'h00000000;
			stopped_nxt = 1'b0;
		end else if (cmd_exec && cmd_r == timer_ctrl_pkg::cmd_stop) begin
			stopped_nxt = 1'b1;
		end else if (wrap) begin
			count_nxt = dir_r ? top_val : 32'h00000000;
			stopped_nxt = single_r;
		end else if (counting) begin
			count_nxt = dir_r ? count_r - 32'h00000001 : count_r + 32'h00000001;
		end
		if (cnt_wr) begin
			count_nxt = hwdata & cnt_mask;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			count_r   <= `RST_COUNT;
			stopped_r <= 1'b0;
		end else if (ce) begin
			count_r   <= count_nxt;
			stopped_r <= stopped_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || wipe_go) begin
			top_r <= `RST_TOP;
		end else if (top_wr) begin
			top_r <= hwdata[7:0];
		end
	end

	// ==========================================================
	// Channels. Wrap wins over a match at the top so MATCH_PULSE_WIDTH_MODE channel zero stays defined.
	for (genvar g = 0; g < 2; g++) begin : g_ch
		wire logic ch_wr;
		assign ch_wr = wr_go & (dp_idx_r == ((g == 0) ? `REG_CH0_IDX : `REG_CH1_IDX));
		assign ch_match[g] = counting & ~cap_r[g] & (count_r == (ch_r[g] & cnt_mask));

		always_comb begin
			wave_nxt[g] = wave_bits_r[g];
			if (wave_sel_r == timer_ctrl_pkg::normal_frequency_mode
				|| wave_sel_r == timer_ctrl_pkg::match_frequency_mode) begin
				if (ch_match[g]) begin
					wave_nxt[g] = ~wave_bits_r[g];
				end
			end else if (wrap) begin
				wave_nxt[g] = ~dir_r;
			end else if (ch_match[g]) begin
				wave_nxt[g] = dir_r;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (rst || wipe_go) begin
				ch_r[g]        <= `RST_CH;
				wave_bits_r[g] <= 1'b0;
				wo_r[g]        <= 1'b0;
			end else if (ce) begin
				if (ch_wr) begin
					ch_r[g] <= hwdata;
				end
				wave_bits_r[g] <= wave_nxt[g];
				wo_r[g]        <= wave_nxt[g] ^ inv_r[g];
			end
		end
	end
	assign waveform_output = wo_r;

	// ==========================================================
	// Read data selection.
	assign rd_main = {5'h00, div_sel_r, 1'b0, wave_sel_r, 1'b0, width_sel_r,
		enable_r, soft_reset_r};
	assign rd_sync_read_trigger = {1'b0, cont_r, 9'h000, rd_target_r};
	assign rd_cb = {cmd_r, 3'h0, single_r, 1'b0, dir_r};
	assign rd_ci = {2'h0, cap_r, 2'h0, inv_r};
	assign rd_status = {lnk.sync_busy, 4'h0, op_rd_r, op_en_r, op_rst_r};
	assign rd_count = (rd_target_r == `REG_COUNT_IDX) ? shadow_r : count_r;
	assign rd_ch0 = (rd_target_r == `REG_CH0_IDX) ? shadow_r : ch_r[0];
	assign rd_ch1 = (rd_target_r == `REG_CH1_IDX) ? shadow_r : ch_r[1];
	assign rd_mux = (dp_idx_r == `REG_MAIN_IDX) ? {16'h0000, rd_main} :
		(dp_idx_r == `REG_SYNC_READ_TRIGGER_IDX) ? {16'h0000, rd_sync_read_trigger} :
		((dp_idx_r == `REG_CLR_IDX) || (dp_idx_r == `REG_SET_IDX)) ? {24'h000000, rd_cb} :
		(dp_idx_r == `REG_CAPINV_IDX) ? {24'h000000, rd_ci} :
		(dp_idx_r == `REG_STATUS_IDX) ? {24'h000000, rd_status} :
		(dp_idx_r == `REG_COUNT_IDX) ? rd_count :
		(dp_idx_r == `REG_TOP_IDX) ? {24'h000000, top_r} :
		(dp_idx_r == `REG_CH0_IDX) ? rd_ch0 :
		(dp_idx_r == `REG_CH1_IDX) ? rd_ch1 : 32'h00000000;
endmodule // timer_counter_control_regs

/* bench/timer_counter_control_regs_checker.sv */
`timescale 1ns/10ps
`include "timer_ctrl_consts.svh"
module timer_counter_control_regs_checker (
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        ce,
	// Register bus.
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata
);
	// ====================
	// Bus phase tracking.
	logic       dph_r;
	logic       wr_r;
	logic [4:0] idx_r;
	wire        tkn = ce & hsel & hready & htrans[1];
	wire        rdv = dph_r & ~wr_r & hreadyout;
	wire        wdn = dph_r & wr_r & hready;
	always_ff @(posedge clk_sys) begin
		if (rst)
			dph_r <= 1'b0;
		else if (ce & hready)
			dph_r <= tkn;
		if (tkn) begin
			wr_r  <= hwrite;
			idx_r <= haddr[6:2];
		end
	end
	// ====================
	// Properties.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_stat_rd;
		tkn && !hwrite && haddr[6:2] == `REG_STATUS_IDX;
	endsequence
	property p_read_wait;
		tkn && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
	property p_trig_zero;
		rdv && idx_r == `REG_SYNC_READ_TRIGGER_IDX |-> !hrdata[15];
	endproperty
	a_trig_zero: assert property (p_trig_zero) else $error("trigger read one");
	property p_sync_read_trigger_bits;
		rdv && idx_r == `REG_SYNC_READ_TRIGGER_IDX |-> (hrdata & ~32'h0000401f) == 32'h0;
	endproperty
	a_sync_read_trigger_bits: assert property (p_sync_read_trigger_bits) else $error("request bits");
	property p_view_bits;
		rdv && idx_r inside {`REG_CLR_IDX, `REG_SET_IDX} |-> (hrdata & ~32'hc5) == 32'h0;
	endproperty
	a_view_bits: assert property (p_view_bits) else $error("view bits");
	property p_ci_bits;
		rdv && idx_r == `REG_CAPINV_IDX |-> (hrdata & ~32'h33) == 32'h0;
	endproperty
	a_ci_bits: assert property (p_ci_bits) else $error("capture bits");
	property p_main_bits;
		rdv && idx_r == `REG_MAIN_IDX |-> (hrdata & ~32'h76f) == 32'h0;
	endproperty
	a_main_bits: assert property (p_main_bits) else $error("main bits");
	property p_en_busy;
		wdn && idx_r == `REG_MAIN_IDX && !hwdata[0] ##1 s_stat_rd |-> ##2 hrdata[1] && hrdata[7];
	endproperty
	a_en_busy: assert property (p_en_busy) else $error("enable not busy");
	property p_rst_busy;
		wdn && idx_r == `REG_MAIN_IDX && hwdata[0] ##1 s_stat_rd |-> ##2 hrdata[0] && hrdata[7];
	endproperty
	a_rst_busy: assert property (p_rst_busy) else $error("reset not busy");
	property p_trig_busy;
		wdn && idx_r == `REG_SYNC_READ_TRIGGER_IDX && hwdata[15] ##1 s_stat_rd |-> ##2 hrdata[2];
	endproperty
	a_trig_busy: assert property (p_trig_busy) else $error("read sync not busy");
	c_rst: cover property (wdn && idx_r == `REG_MAIN_IDX && hwdata[0]);
	c_trig: cover property (wdn && idx_r == `REG_SYNC_READ_TRIGGER_IDX && hwdata[15]);
	c_stat: cover property (rdv && idx_r == `REG_STATUS_IDX);
endmodule // timer_counter_control_regs_checker

bind timer_counter_control_regs timer_counter_control_regs_checker chk_u (
	.clk_sys, .rst, .ce, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hrdata
);

/* bench/test_timer_counter_control_regs.sv */
`timescale 1ns/10ps
`include "timer_ctrl_consts.svh"
`define CK(n, e, g) begin n_compared++; if ((e) !== (g)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module test_timer_counter_control_regs;
	// ====================
	// Signals and bookkeeping.
	typedef struct {string nm; logic [31:0] m; logic [31:0] v;} exp_t;
	localparam logic [4:0] ri [6] = '{`REG_MAIN_IDX, `REG_SYNC_READ_TRIGGER_IDX, `REG_CLR_IDX,
		`REG_CAPINV_IDX, `REG_TOP_IDX, 5'h07};
	localparam int fac [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
	localparam int wm [4] = '{1, 2, 0, 0};
	localparam int nt [4] = '{20, 20, 10, 0};
	logic        clk_sys;
	logic        rst;
	logic        ce;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	wire         hreadyout;
	wire  [31:0] hrdata;
	wire  [1:0]  waveform_output;
	int          mismatches;
	int          n_compared;
	int          tg;
	logic        pv;
	logic        pend_r;
	logic [31:0] rv;
	logic [31:0] c0;
	exp_t        q [$];
	exp_t        e;
	// The bus waits on the design's own ready, so hready is hreadyout.
	timer_counter_control_regs dut_u (
		.clk_sys, .rst, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(),
		.hrdata, .waveform_output
	);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ====================
	// Read checker: oldest note against each finished read.
	always @(posedge clk_sys) begin
		if (pend_r && hreadyout === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			`CK(e.nm, e.v, hrdata & e.m)
		end
		if (hreadyout === 1'b1)
			pend_r <= !rst && htrans[1] && !hwrite;
	end
	// ====================
	// Bus tasks.
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Ready is looked at on the falling edge, where it has settled.
	task wait_rdy;
		int n;
		n = 0;
		@(negedge clk_sys);
		while (hreadyout !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 40) begin
			mismatches++;
			tally_and_finish;
		end
		@(posedge clk_sys);
	endtask
	task bus(input logic w, input logic [4:0] i, input logic [31:0] d);
		haddr <= {25'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= w ? d : $urandom;
		wait_rdy;
		rv = hrdata;
	endtask
	task wr(input logic [4:0] i, input logic [31:0] d);
		bus(1'b1, i, d);
	endtask
	task rd(input string s, input logic [4:0] i, input logic [31:0] m, input logic [31:0] v);
		q.push_back('{s, m, v});
		bus(1'b0, i, 32'h0);
	endtask
	task idle;
		int n;
		n = 0;
		do begin
			rd("poll", `REG_STATUS_IDX, 32'h0, 32'h0);
			n++;
		end while (rv[7] !== 1'b0 && n < 10);
		`CK("sync_idle", 32'h0, rv & 32'h87)
	endtask
	task chk_reset;
		for (int k = 0; k < 6; k++)
			rd("reset", ri[k], 32'hffffffff, (k == 4) ? 32'hff : 32'h0);
	endtask
	// ====================
	// Main sequence.
	initial begin
		void'($urandom(29));
		{rst, ce, haddr, htrans, hwrite, hwdata, pend_r} = {2'h3, 68'h0};
		{mismatches, n_compared} = 64'h0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk_reset;
		wr(`REG_MAIN_IDX, 32'h2);
		rd("en_busy", `REG_STATUS_IDX, 32'h82, 32'h82);
		rd("en_back", `REG_MAIN_IDX, 32'h2, 32'h2);
		idle;
		wr(`REG_MAIN_IDX, 32'h76e);
		idle;
		rd("protect", `REG_MAIN_IDX, 32'h76f, 32'h2);
		wr(`REG_MAIN_IDX, 32'h0);
		idle;
		for (int k = 0; k < 4; k++) begin
			wr(`REG_MAIN_IDX, (k << 5) | (k << 2));
			rd("modes", `REG_MAIN_IDX, 32'h6c, (k << 5) | (k << 2));
			idle;
		end
		// Any window of eight prescaled periods holds exactly eight ticks.
		for (int d = 0; d < 8; d++) begin
			wr(`REG_MAIN_IDX, (d << 8) | 32'h2);
			idle;
			rd("cnt", `REG_COUNT_IDX, 32'h0, 32'h0);
			c0 = rv;
			repeat (8 * fac[d] - 3) @(posedge clk_sys);
			rd("cnt", `REG_COUNT_IDX, 32'h0, 32'h0);
			`CK("div_span", c0 + 32'h8, rv)
			wr(`REG_MAIN_IDX, 32'h0);
			idle;
		end
		wr(`REG_SET_IDX, 32'h45);
		rd("set_clr", `REG_CLR_IDX, 32'hff, 32'h45);
		wr(`REG_CLR_IDX, 32'hc1);
		rd("cancel", `REG_SET_IDX, 32'hff, 32'h04);
		wr(`REG_MAIN_IDX, 32'h2);
		idle;
		for (int c = 1; c < 4; c++) begin
			wr(`REG_SET_IDX, c << 6);
			rd("cmd_done", `REG_CLR_IDX, 32'hc0, 32'h0);
		end
		rd("cnt", `REG_COUNT_IDX, 32'h0, 32'h0);
		c0 = rv;
		rd("stopped", `REG_COUNT_IDX, 32'hffffffff, c0);
		wr(`REG_SET_IDX, 32'h40);
		rd("cnt", `REG_COUNT_IDX, 32'h0, 32'h0);
		`CK("restart", 1'b1, rv < 32'h4)
		// Twenty frozen cycles inside a span of twenty-three leave three counts.
		c0 = rv;
		ce <= 1'b0;
		repeat (20) @(posedge clk_sys);
		ce <= 1'b1;
		rd("cnt", `REG_COUNT_IDX, 32'h0, 32'h0);
		`CK("freeze", c0 + 32'h3, rv)
		wr(`REG_CAPINV_IDX, 32'h33);
		wr(`REG_TOP_IDX, $urandom & 32'hff);
		wr(`REG_MAIN_IDX, 32'h76f);
		rd("rst_busy", `REG_STATUS_IDX, 32'h81, 32'h81);
		idle;
		chk_reset;
		wr(`REG_SYNC_READ_TRIGGER_IDX, 32'h8010);
		rd("rd_busy", `REG_STATUS_IDX, 32'h84, 32'h84);
		idle;
		rd("target", `REG_SYNC_READ_TRIGGER_IDX, 32'hffff, 32'h0010);
		wr(`REG_SYNC_READ_TRIGGER_IDX, 32'hc010);
		rd("cont", `REG_SYNC_READ_TRIGGER_IDX, 32'hffff, 32'h4010);
		idle;
		wr(`REG_CAPINV_IDX, 32'h3);
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		`CK("invert", 2'h3, waveform_output)
		@(posedge clk_sys);
		wr(`REG_TOP_IDX, 32'h5);
		wr(`REG_CH0_IDX, 32'h2);
		// Match mode first, while the count is still below the small top.
		// The last pass puts channel zero in capture, so its compare must stay silent.
		for (int m = 0; m < 4; m++) begin
			wr(`REG_CAPINV_IDX, (m == 3) ? 32'h10 : 32'h0);
			wr(`REG_MAIN_IDX, (wm[m] << 5) | 32'h6);
			idle;
			// Settle first, so the pulse width output has seen both edges once.
			repeat (12) @(posedge clk_sys);
			{tg, pv} = {32'h0, waveform_output[0]};
			repeat (60) begin
				@(negedge clk_sys);
				tg += (waveform_output[0] !== pv);
				pv = waveform_output[0];
			end
			`CK("toggles", nt[m], tg)
			@(posedge clk_sys);
			wr(`REG_MAIN_IDX, 32'h0);
			idle;
		end
		// Down counting in single run wraps to the top once and stays there.
		wr(`REG_SET_IDX, 32'h5);
		wr(`REG_MAIN_IDX, 32'h6);
		idle;
		repeat (10) @(posedge clk_sys);
		rd("single", `REG_COUNT_IDX, 32'hffffffff, 32'h5);
		@(posedge clk_sys);
		tally_and_finish;
	end
endmodule // test_timer_counter_control_regs
